// ### inc/ccp_cfg.svh
// ccp_cfg.svh: register offsets, field positions, reset values, counts
// assumes: included by the ccp package users; definitions only
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

`define CCP_OFF_CTRL      12'h000
`define CCP_OFF_CAP       12'h004
`define CCP_OFF_HOLD      12'h008
`define CCP_OFF_STAT      12'h00c
`define CCP_OFF_TIMER     12'h010

`define CCP_CTRL_EN_BIT   7
`define CCP_CTRL_OUT_BIT  5
`define CCP_CTRL_FMT_BIT  4
`define CCP_CTRL_RST      8'h00
`define CCP_CAP_RST       8'h00
`define CCP_HOLD_RST      16'h0000

`define CCP_STAT_IF_BIT   0
`define CCP_STAT_IE_BIT   1
`define CCP_STAT_ADSEL_BIT 2

`define CCP_PRE_FOUR      2'h3
`define CCP_PRE_SIXTEEN   4'hf

`endif

// ### inc/ccp_pkg.sv
// ccp_pkg: types of the capture/compare/pwm channel
// assumes: ccp_cfg.svh carries the numeric constants
package ccp_pkg;

    typedef enum logic [3:0] {
        CCP_MODE_OFF      = 4'b0000,
        CCP_MODE_CMP_TGLR = 4'b0001,
        CCP_MODE_CMP_TGL  = 4'b0010,
        CCP_MODE_CAP_FALL = 4'b0100,
        CCP_MODE_CAP_RISE = 4'b0101,
        CCP_MODE_CAP_4TH  = 4'b0110,
        CCP_MODE_CAP_16TH = 4'b0111,
        CCP_MODE_CMP_SET  = 4'b1000,
        CCP_MODE_CMP_CLR  = 4'b1001,
        CCP_MODE_CMP_SWI  = 4'b1010,
        CCP_MODE_CMP_ADC  = 4'b1011,
        CCP_MODE_PWM      = 4'b1111
    } ccp_mode_t;

    // capture event sources as one packed group
    typedef struct packed {
        logic logic_cell_four_output;
        logic logic_cell_three_output;
        logic logic_cell_two_output;
        logic logic_cell_one_output;
        logic pin_change_event;
        logic comparator_two_synced;
        logic comparator_one_synced;
        logic routed_input_pin;
    } ccp_src_t;

    // pwm timer state supplied by the pwm timer
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] period;
        logic [1:0] low_bits;
        logic       inc;
    } ccp_pwm_tmr_t;

endpackage

// ### src/ccp_unit.sv
// ccp_unit: one capture/compare/pwm channel with an apb register slave
// assumes: capture timer and pwm timer live outside and are on pclk;
// timer increments arrive as one-cycle enables
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "ccp_cfg.svh"

// Functional notes
// - capture copies capture timer into holding pair
// - mode picks falling, rising, 4th, 16th edge
// - capture sets sticky flag, software clears
// - later capture overwrites, no overrun indication
// - three-bit field selects one of eight sources
// - port write on output pin may capture
// - mode change may false flag; software clears
// - prescaler cleared when off, non-capture, reset
// - prescale switch keeps counter; clear control first
// - capture in sleep needs external timer clock
// - compare holding pair against capture timer
// - match toggles, sets, clears, triggers or flags
// - every compare match sets the flag
// - adc trigger only when channel selected
// - holding change after trigger cancels timer reset
// - writing zero control clears output latch
// - channel output offered to other peripherals
// - match interrupt wakes device when enabled
// - pwm up to ten bits from period and duty
// - period end clears timer, sets output unless duty is zero, loads duty
// - ten-bit time base; clear at buffered duty
// - duty beyond period leaves output unchanged
module ccp_unit
    import ccp_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire ccp_src_t     sources,
    input  wire logic [15:0]  capture_timer,
    input  wire ccp_pwm_tmr_t pwm_tmr,
    input  wire logic         pin_is_output,
    input  wire logic         port_level,
    output logic              channel_out,
    output logic              adc_trigger,
    output logic              capture_timer_reset,
    output logic              pwm_timer_clear,
    output logic              wake_request
);

    logic [7:0]  ctrl_q;
    logic [2:0]  cap_src_q;
    logic [15:0] hold_q;
    logic        flag_q;
    logic        ie_q;
    logic        adsel_q;
    logic        out_q;
    logic [3:0]  pre_cnt_q;
    logic        src_s1_q;
    logic        src_s2_q;
    logic        src_prev_q;
    logic [9:0]  duty_buf_q;
    logic        trig_q;
    logic        match_prev_q;

    ccp_mode_t   mode;
    logic        enabled;
    logic        is_capture;
    logic        is_compare;
    logic        is_pwm;
    logic        wr_en;
    logic        rd_en;
    logic        hold_wr;
    logic        ctrl_wr;
    logic        src_raw;
    logic        rise;
    logic        fall;
    logic        cap_event;
    logic        cmp_match;
    logic        match_edge;
    logic [9:0]  duty_now;
    logic [9:0]  time_base;
    logic        period_end;
    logic        unmapped;

    assign mode       = ccp_mode_t'(ctrl_q[3:0]);
    assign enabled    = ctrl_q[`CCP_CTRL_EN_BIT];
    assign is_capture = enabled && (ctrl_q[3:2] == 2'b01);
    assign is_pwm     = enabled && (mode == CCP_MODE_PWM);
    assign is_compare = enabled && !is_capture && !is_pwm
                        && (mode != CCP_MODE_OFF);

    // apb: zero wait states, error on unmapped offsets
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign unmapped = !(paddr == `CCP_OFF_CTRL || paddr == `CCP_OFF_CAP
                      || paddr == `CCP_OFF_HOLD || paddr == `CCP_OFF_STAT
                      || paddr == `CCP_OFF_TIMER);
    assign pslverr = psel && penable && unmapped;
    assign ctrl_wr = wr_en && (paddr == `CCP_OFF_CTRL);
    assign hold_wr = wr_en && (paddr == `CCP_OFF_HOLD);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `CCP_OFF_CTRL:  prdata <= {24'h00_0000, ctrl_q[7:6],
                                           out_q, ctrl_q[4:0]};
                `CCP_OFF_CAP:   prdata <= {29'h0000_0000, cap_src_q};
                `CCP_OFF_HOLD:  prdata <= {16'h0000, hold_q};
                `CCP_OFF_STAT:  prdata <= {29'h0000_0000, adsel_q,
                                           ie_q, flag_q};
                `CCP_OFF_TIMER: prdata <= {16'h0000, capture_timer};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `CCP_CTRL_RST;
            cap_src_q <= 3'h0;
            ie_q      <= 1'b0;
            adsel_q   <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= pwdata[7:0];
            end
            if (wr_en && paddr == `CCP_OFF_CAP) begin
                cap_src_q <= pwdata[2:0];
            end
            if (wr_en && paddr == `CCP_OFF_STAT) begin
                ie_q    <= pwdata[`CCP_STAT_IE_BIT];
                adsel_q <= pwdata[`CCP_STAT_ADSEL_BIT];
            end
        end
    end

    // source select then two-flop sync; only the second stage is watched
    always_comb begin
        src_raw = sources[cap_src_q];
        if (cap_src_q == 3'h0 && pin_is_output) begin
            src_raw = port_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_s1_q   <= 1'b0;
            src_s2_q   <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            src_s1_q   <= src_raw;
            src_s2_q   <= src_s1_q;
            src_prev_q <= src_s2_q;
        end
    end

    assign rise = src_s2_q && !src_prev_q;
    assign fall = !src_s2_q && src_prev_q;

    // prescaler keeps counting across prescale changes; software
    // must clear control first to restart it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 4'h0;
        end else if (!is_capture) begin
            pre_cnt_q <= 4'h0;
        end else if (rise) begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
        end
    end

    always_comb begin
        cap_event = 1'b0;
        if (is_capture) begin
            case (mode)
                CCP_MODE_CAP_FALL: cap_event = fall;
                CCP_MODE_CAP_RISE: cap_event = rise;
                CCP_MODE_CAP_4TH:  cap_event = rise &&
                    (pre_cnt_q[1:0] == `CCP_PRE_FOUR);
                CCP_MODE_CAP_16TH: cap_event = rise &&
                    (pre_cnt_q == `CCP_PRE_SIXTEEN);
                default:           cap_event = 1'b0;
            endcase
        end
    end

    // holding pair: capture overwrites silently; software writes too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= `CCP_HOLD_RST;
        end else if (cap_event) begin
            hold_q <= capture_timer;
        end else if (hold_wr) begin
            hold_q <= pwdata[15:0];
        end
    end

    assign cmp_match  = is_compare && (hold_q == capture_timer);
    assign match_edge = cmp_match && !match_prev_q;

    // set beats a software clear landing in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (cap_event || match_edge) begin
            flag_q <= 1'b1;
        end else if (wr_en && paddr == `CCP_OFF_STAT
                     && !pwdata[`CCP_STAT_IF_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    assign wake_request = flag_q && ie_q;

    // pwm duty in ten bits, left or right aligned by fmt
    assign duty_now = ctrl_q[`CCP_CTRL_FMT_BIT] ? hold_q[15:6]
                                                 : hold_q[9:0];
    assign time_base  = {pwm_tmr.count, pwm_tmr.low_bits};
    assign period_end = is_pwm && pwm_tmr.inc
                        && (pwm_tmr.count == pwm_tmr.period);
    assign pwm_timer_clear = period_end;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_buf_q <= 10'h000;
        end else if (period_end) begin
            duty_buf_q <= duty_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
        end else if (ctrl_wr && pwdata[7:0] == 8'h00) begin
            out_q <= 1'b0;
        end else if (is_pwm) begin
            if (period_end) begin
                out_q <= (duty_now != 10'h000);
            end else if (time_base + 10'h001 == duty_buf_q
                         && duty_buf_q <= {pwm_tmr.period, 2'b11}) begin
                // fall as the time base steps onto the duty so the pulse
                // lasts duty steps; exact only at one step per clock
                out_q <= 1'b0;
            end
        end else if (match_edge) begin
            case (mode)
                CCP_MODE_CMP_TGLR,
                CCP_MODE_CMP_TGL: out_q <= !out_q;
                CCP_MODE_CMP_SET: out_q <= 1'b1;
                CCP_MODE_CMP_CLR: out_q <= 1'b0;
                default:          out_q <= out_q;
            endcase
        end
    end

    assign channel_out = out_q;

    // trigger one cycle, timer reset the next in CCP_MODE_CMP_ADC or CCP_MODE_CMP_TGLR unless holding changed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q       <= 1'b0;
            match_prev_q <= 1'b0;
            adc_trigger  <= 1'b0;
            capture_timer_reset <= 1'b0;
        end else begin
            match_prev_q <= cmp_match;
            trig_q       <= match_edge && adsel_q;
            adc_trigger  <= match_edge && adsel_q;
            capture_timer_reset <= trig_q && !hold_wr
                && (mode == CCP_MODE_CMP_ADC
                    || mode == CCP_MODE_CMP_TGLR);
        end
    end

    flag_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_event |=> flag_q)
        else $error("capture did not set flag");
    cap_copy_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_event |=> hold_q == $past(capture_timer))
        else $error("capture value not held");
    pre_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !is_capture |=> pre_cnt_q == 4'h0)
        else $error("prescaler not cleared");
    zero_ctrl_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr && pwdata[7:0] == 8'h00 |=> !channel_out)
        else $error("output latch not cleared");
    adc_sel_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        adc_trigger |-> $past(adsel_q))
        else $error("trigger without selection");
    cmp_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        match_edge |=> flag_q)
        else $error("match did not flag");
    tmr_rst_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture_timer_reset |-> $past(adc_trigger) && !$past(hold_wr))
        else $error("timer reset without trigger");
    pwm_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        period_end |=> duty_buf_q == $past(duty_now))
        else $error("duty not buffered");
    src_sync_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rise |-> $past(src_raw, 2))
        else $error("edge not synced");

    // flag stickiness, capture edges, match actions and pwm output
    flag_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        flag_q && !(wr_en && paddr == `CCP_OFF_STAT
                    && !pwdata[`CCP_STAT_IF_BIT]) |=> flag_q)
        else $error("flag dropped by hardware");
    fall_cap_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_capture && mode == CCP_MODE_CAP_FALL && fall
        |=> flag_q && hold_q == $past(capture_timer))
        else $error("falling edge not captured");
    rise_cap_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_capture && mode == CCP_MODE_CAP_RISE && rise
        |=> flag_q && hold_q == $past(capture_timer))
        else $error("rising edge not captured");
    cmp_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        match_edge && mode == CCP_MODE_CMP_SET && !ctrl_wr
        |=> channel_out)
        else $error("set on match failed");
    cmp_clr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        match_edge && mode == CCP_MODE_CMP_CLR && !ctrl_wr
        |=> !channel_out)
        else $error("clear on match failed");
    cmp_tgl_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        match_edge && !ctrl_wr && (mode == CCP_MODE_CMP_TGL
            || mode == CCP_MODE_CMP_TGLR)
        |=> channel_out != $past(channel_out))
        else $error("toggle on match failed");
    pwm_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        period_end && duty_now != 10'h000 && !ctrl_wr
        |=> channel_out)
        else $error("output not set at period end");
    pwm_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_pwm && !period_end && !ctrl_wr
        && duty_buf_q > {pwm_tmr.period, 2'b11} |=> $stable(channel_out))
        else $error("output moved with long duty");
    trig_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        adc_trigger |=> !adc_trigger)
        else $error("trigger longer than one cycle");
    wake_req_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        flag_q && ie_q |-> wake_request)
        else $error("enabled flag did not wake");

endmodule

// ### test/ccp_far_model.sv
// ccp_far_model: capture timer and pwm timer beside one channel
// assumes: shares pclk with the channel; the bench steers run, load, period
`timescale 1ns/100ps
module ccp_far_model
    import ccp_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         run,
    input  wire logic         load,
    input  wire logic [15:0]  load_val,
    input  wire logic         pwm_run,
    input  wire logic [7:0]   period,
    input  wire logic         capture_timer_reset,
    input  wire logic         pwm_timer_clear,
    output logic      [15:0]  capture_timer,
    output ccp_pwm_tmr_t      pwm_tmr
);
    logic [7:0] cnt_q;
    logic [1:0] lo_q;

    // low bits stand in for the clock phase at 1:1 prescale
    assign pwm_tmr = {cnt_q, period, lo_q, pwm_run & (lo_q == 2'h3)};

    // synchronous timer on the instruction clock, never free of it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            capture_timer <= 16'h0000;
        else if (capture_timer_reset)
            capture_timer <= 16'h0000;
        else if (load)
            capture_timer <= load_val;
        else if (run)
            capture_timer <= capture_timer + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_q <= 2'h0;
            cnt_q <= 8'h00;
        end else if (pwm_run) begin
            lo_q <= lo_q + 2'h1;
            if (pwm_tmr.inc && (pwm_timer_clear || cnt_q == period))
                cnt_q <= 8'h00;
            else if (pwm_tmr.inc)
                cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// ### test/tb.sv
// tb: self-checking bench for one capture/compare/pwm channel
// assumes: ccp_pkg compiled first, ccp_cfg.svh on the include path
`timescale 1ns/100ps
`include "ccp_cfg.svh"
module tb
    import ccp_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, err, t_run;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         pready, pslverr, pin_is_output, port_level, load;
    ccp_src_t     sources;
    logic [15:0]  capture_timer, load_val, t;
    ccp_pwm_tmr_t pwm_tmr;
    logic         channel_out, adc_trigger, capture_timer_reset;
    logic         pwm_timer_clear, wake_request, pwm_run;
    logic [7:0]   period;
    logic [7:0]   cmp_ctl [8] = '{8'h88, 8'h82, 8'h81, 8'h8a,
                                  8'h8b, 8'h89, 8'h88, 8'h8b};
    logic [7:0]   cmp_out = 8'hdd;
    int           duty [5] = '{0, 1, 17, 31, 40};
    int           miscompares, compares, adc_n, crst_n, hi_n, n, h0, a0, c0;
    logic [15:0]  capq [$];

    ccp_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sources(sources), .capture_timer(capture_timer), .pwm_tmr(pwm_tmr),
        .pin_is_output(pin_is_output), .port_level(port_level),
        .channel_out(channel_out), .adc_trigger(adc_trigger),
        .capture_timer_reset(capture_timer_reset),
        .pwm_timer_clear(pwm_timer_clear), .wake_request(wake_request));
    ccp_far_model far (.pclk(pclk), .presetn(presetn), .run(t_run),
        .load(load), .load_val(load_val), .pwm_run(pwm_run),
        .period(period), .capture_timer_reset(capture_timer_reset),
        .pwm_timer_clear(pwm_timer_clear), .capture_timer(capture_timer),
        .pwm_tmr(pwm_tmr));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // sampled mid-cycle so counts never race the launching edge
    always @(negedge pclk) begin
        adc_n += (adc_trigger === 1'b1);
        crst_n += (capture_timer_reset === 1'b1);
        hi_n += (channel_out === 1'b1);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settmr(input logic [15:0] v);
        @(posedge pclk);
        load <= 1'b1;
        load_val <= v;
        @(posedge pclk);
        load <= 1'b0;
    endtask

    // k rises each followed by a fall, each level held long enough to pass the synchroniser
    task automatic pulses(input int k, input int sel);
        repeat (k) begin
            for (int lv = 1; lv >= 0; lv--) begin
                @(posedge pclk);
                sources <= pin_is_output ? 8'h00 : 8'(lv) << sel;
                port_level <= pin_is_output & lv[0];
                repeat (5) @(posedge pclk);
            end
        end
    endtask

    task automatic results();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #(100 * 40000);
        miscompares++;
        results();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sources, pin_is_output, port_level, t_run, load, load_val} = '0;
        {pwm_run, period} = '0;
        void'($urandom(8));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk(rd, 32'h0);
            chk(32'(err), 32'(i == 5));
        end
        for (int i = 0; i < 9; i++) begin
            n = (i % 4 == 2) ? 4 : (i % 4 == 3) ? 16 : 1;
            pin_is_output <= (i == 8);
            apb(1'b1, `CCP_OFF_CTRL, 32'h0);
            apb(1'b1, `CCP_OFF_CAP, 32'(i % 8));
            apb(1'b1, `CCP_OFF_CTRL, 32'h84 + 32'(i % 4));
            apb(1'b1, `CCP_OFF_STAT, 32'h0);
            settmr(16'($urandom));
            pulses(n - 1, i % 8);
            apb(1'b0, `CCP_OFF_STAT, 32'h0);
            chk(rd & 32'h1, 32'h0);
            pulses(1, i % 8);
            t = 16'($urandom);
            capq.push_back(t);
            settmr(t);
            pulses(n, i % 8);
            apb(1'b0, `CCP_OFF_HOLD, 32'h0);
            chk(rd, 32'(capq[$]));
            apb(1'b0, `CCP_OFF_STAT, 32'h0);
            chk(rd & 32'h1, 32'h1);
        end
        apb(1'b1, `CCP_OFF_CTRL, 32'h86);
        pulses(1, 0);
        apb(1'b1, `CCP_OFF_CTRL, 32'h0);
        apb(1'b1, `CCP_OFF_CTRL, 32'h86);
        apb(1'b1, `CCP_OFF_STAT, 32'h0);
        pulses(3, 0);
        apb(1'b0, `CCP_OFF_STAT, 32'h0);
        chk(rd & 32'h1, 32'h0);
        pin_is_output <= 1'b0;
        apb(1'b1, `CCP_OFF_CTRL, 32'h0);
        apb(1'b1, `CCP_OFF_HOLD, 32'h1234);
        for (int j = 0; j < 8; j++) begin
            apb(1'b1, `CCP_OFF_CTRL, 32'(cmp_ctl[j]));
            apb(1'b1, `CCP_OFF_STAT, (j < 7) ? 32'h6 : 32'h2);
            settmr(16'h1230);
            a0 = adc_n;
            c0 = crst_n;
            t_run <= 1'b1;
            repeat (12) @(posedge pclk);
            t_run <= 1'b0;
            chk(32'(channel_out), 32'(cmp_out[j]));
            chk(32'(adc_n - a0), 32'(j < 7));
            chk(32'(crst_n - c0), 32'(j == 2 || j == 4));
            apb(1'b0, `CCP_OFF_STAT, 32'h0);
            chk(rd & 32'h1, 32'h1);
            chk(32'(wake_request), 32'h1);
        end
        apb(1'b1, `CCP_OFF_CTRL, 32'h0);
        @(negedge pclk);
        chk(32'(channel_out), 32'h0);
        period <= 8'h07;
        pwm_run <= 1'b1;
        for (int j = 0; j < 5; j++) begin
            apb(1'b1, `CCP_OFF_HOLD, 32'(duty[j]));
            apb(1'b1, `CCP_OFF_CTRL, 32'h8f);
            repeat (64) @(posedge pclk);
            h0 = hi_n;
            repeat (32) @(posedge pclk);
            chk(32'(hi_n - h0), 32'(duty[j] > 32 ? 32 : duty[j]));
        end
        results();
    end
endmodule
